// ### gpio_port.sv
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int NPINS = PIN_COUNT
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic      [1:0]       s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic      [31:0]      s_axi_rdata,
  output logic      [1:0]       s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic [NPINS-1:0] pin_in,
  output logic      [NPINS-1:0] pin_out,
  output logic      [NPINS-1:0] pin_oe,
  input  wire logic [NPINS-1:0] periph_out,
  input  wire logic [NPINS-1:0] periph_oe,
  output logic      [NPINS-1:0] periph_in,
  output logic                  irq
);

  // The register layout packs one bit per pin into the low byte only.
  if (NPINS != PIN_COUNT) begin : g_bad_npins
    $error("gpio_port supports exactly eight pins");
  end

  // Pin configuration, one bit per pin in the low byte.
  logic [7:0]  dir_out_reg, dir_out_next;
  logic [7:0]  dir_hw_reg, dir_hw_next;
  logic [7:0]  out_data_reg, out_data_next;
  logic [7:0]  in_en_reg, in_en_next;
  logic [7:0]  trig_level_reg, trig_level_next;
  logic [7:0]  trig_both_reg, trig_both_next;
  logic [7:0]  trig_high_reg, trig_high_next;
  logic [7:0]  irq_en_reg, irq_en_next;
  logic [7:0]  select_reg, select_next;
  logic [7:0]  clear_sel;
  logic [7:0]  pin_sync_lvl;
  logic [7:0]  pin_level;
  logic [7:0]  raw_status;
  logic [7:0]  masked_status;
  logic        irq_reg, irq_next;

  // Bus channel state; each write half keeps its own held flag.
  logic        aw_held_reg, aw_held_next;
  logic        w_held_reg, w_held_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic        wlane0_reg, wlane0_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        do_write;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_byte;
  logic        wr_lane0;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_word;

  // Returns the direction mode a pin's two configuration bits give.
  function automatic dir_mode_t pin_mode(input logic hw, input logic out);
    if (hw) begin
      return dir_hardware_control;
    end else if (out) begin
      return DIR_SW_OUTPUT;
    end
    return DIR_SW_INPUT;
  endfunction

  // Zero-extends a pin byte into a bus word.
  function automatic logic [31:0] pin_word(input logic [7:0] bits);
    return {24'h000000, bits};
  endfunction

  // True for any mapped register offset.
  function automatic logic is_mapped(input logic [7:0] addr);
    case (addr)
      OFS_DIR_OUT, OFS_DIR_HW, OFS_OUT_DATA, OFS_IN_ENABLE, OFS_TRIG_LEVEL, OFS_TRIG_BOTH,
      OFS_TRIG_HIGH, OFS_IRQ_MASK_OP, OFS_IRQ_UNMASK, OFS_IRQ_CLEAR, OFS_IRQ_RAW,
      OFS_IRQ_MASKED, OFS_IRQ_ENABLED, OFS_PIN_SELECT, OFS_PIN_LEVEL: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // True for an aligned, mapped register address; anything else is refused.
  function automatic logic is_legal(input logic [7:0] addr);
    return is_mapped(addr) && addr[1:0] == 2'b00;
  endfunction

  pin_sync #(
    .WIDTH (8)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (pin_in),
    .sync_out (pin_sync_lvl)
  );

  // Input buffers stay off until software enables them, so disabled pins read low.
  assign pin_level = pin_sync_lvl & in_en_reg;

  irq_detect #(
    .WIDTH (8)
  ) u_detect (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .level_in   (pin_level),
    .trig_level (trig_level_reg),
    .trig_both  (trig_both_reg),
    .trig_high  (trig_high_reg),
    .clear_sel  (clear_sel),
    .raw_status (raw_status)
  );

  // Masked status gates the raw events with the unmask state.
  assign masked_status = raw_status & irq_en_reg;
  assign irq           = irq_reg;

  // The line is registered so that it cannot glitch while status bits settle; it trails them by one edge.
  always_comb begin
    irq_next = |masked_status;
  end

  // Pad multiplexing: hardware mode hands pin i only to peripheral signal i, never another.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      case (pin_mode(dir_hw_reg[i], dir_out_reg[i]))
        dir_hardware_control: begin
          pin_out[i] = periph_out[i];
          pin_oe[i]  = periph_oe[i];
        end
        DIR_SW_OUTPUT: begin
          pin_out[i] = out_data_reg[i];
          pin_oe[i]  = 1'b1;
        end
        default: begin
          pin_out[i] = 1'b0;
          pin_oe[i]  = 1'b0;
        end
      endcase
    end
    // Peripheral inputs see only enabled pins that are under hardware control.
    periph_in = pin_level & dir_hw_reg;
  end

  // Write channel capture: address and data are taken in either order.
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wlane0_next  = wlane0_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wlane0_next = s_axi_wstrb[0];
    end
    // The response waits until both halves are held, so a lone address never writes.
    if (aw_held_reg && w_held_reg) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = is_legal(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  // A write lands only with lane zero enabled, since that lane carries the whole pin byte.
  assign do_write = aw_held_reg && w_held_reg;
  assign wr_addr  = awaddr_reg;
  assign wr_byte  = wdata_reg[SEL_LSB +: 8];
  assign wr_lane0 = wlane0_reg;
  assign wr_hit   = do_write && wr_lane0;

  // Register file; the mask, unmask and clear offsets act only on the pins whose bits are set in the written byte.
  always_comb begin
    dir_out_next    = dir_out_reg;
    dir_hw_next     = dir_hw_reg;
    out_data_next   = out_data_reg;
    in_en_next      = in_en_reg;
    trig_level_next = trig_level_reg;
    trig_both_next  = trig_both_reg;
    trig_high_next  = trig_high_reg;
    irq_en_next     = irq_en_reg;
    select_next     = select_reg;
    clear_sel       = 8'h00;
    if (wr_hit) begin
      case (wr_addr)
        OFS_DIR_OUT:     dir_out_next = wr_byte;
        OFS_DIR_HW:      dir_hw_next = wr_byte;
        OFS_OUT_DATA:    out_data_next = wr_byte;
        OFS_IN_ENABLE:   in_en_next = wr_byte;
        OFS_TRIG_LEVEL:  trig_level_next = wr_byte;
        OFS_TRIG_BOTH:   trig_both_next = wr_byte;
        OFS_TRIG_HIGH:   trig_high_next = wr_byte;
        OFS_IRQ_MASK_OP: irq_en_next = irq_en_reg & ~wr_byte;
        OFS_IRQ_UNMASK:  irq_en_next = irq_en_reg | wr_byte;
        OFS_IRQ_CLEAR:   clear_sel = wr_byte;
        OFS_PIN_SELECT:  select_next = wr_byte;
        default:         clear_sel = 8'h00;
      endcase
    end
  end

  // Read path: one cycle from address acceptance to rvalid.
  always_comb begin
    rd_hit  = is_legal(s_axi_araddr);
    rd_word = 32'h00000000;
    case (s_axi_araddr)
      OFS_DIR_OUT:     rd_word = pin_word(dir_out_reg);
      OFS_DIR_HW:      rd_word = pin_word(dir_hw_reg);
      OFS_OUT_DATA:    rd_word = pin_word(out_data_reg);
      OFS_IN_ENABLE:   rd_word = pin_word(in_en_reg);
      OFS_TRIG_LEVEL:  rd_word = pin_word(trig_level_reg);
      OFS_TRIG_BOTH:   rd_word = pin_word(trig_both_reg);
      OFS_TRIG_HIGH:   rd_word = pin_word(trig_high_reg);
      OFS_IRQ_RAW:     rd_word = pin_word(raw_status);
      OFS_IRQ_MASKED:  rd_word = pin_word(masked_status);
      OFS_IRQ_ENABLED: rd_word = pin_word(irq_en_reg);
      OFS_PIN_SELECT:  rd_word = pin_word(select_reg);
      OFS_PIN_LEVEL:   rd_word = pin_word(pin_level & select_reg);
      default:         rd_word = 32'h00000000;
    endcase
    // A new answer is loaded only after the previous one has been taken.
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_next  = rd_word;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // Configuration and interrupt line; reset leaves every pad undriven and the line quiet.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_out_reg    <= RST_DIR_OUT;
      dir_hw_reg     <= RST_DIR_HW;
      out_data_reg   <= RST_OUT_DATA;
      in_en_reg      <= RST_IN_ENABLE;
      trig_level_reg <= RST_TRIG;
      trig_both_reg  <= RST_TRIG;
      trig_high_reg  <= RST_TRIG;
      irq_en_reg     <= RST_IRQ_EN;
      select_reg     <= RST_SELECT;
      irq_reg        <= 1'b0;
    end else begin
      dir_out_reg    <= dir_out_next;
      dir_hw_reg     <= dir_hw_next;
      out_data_reg   <= out_data_next;
      in_en_reg      <= in_en_next;
      trig_level_reg <= trig_level_next;
      trig_both_reg  <= trig_both_next;
      trig_high_reg  <= trig_high_next;
      irq_en_reg     <= irq_en_next;
      select_reg     <= select_next;
      irq_reg        <= irq_next;
    end
  end

  // Write channel state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg    <= 1'b0;
      w_held_reg     <= 1'b0;
      awaddr_reg     <= 8'h00;
      wdata_reg      <= 32'h00000000;
      wlane0_reg     <= 1'b0;
      bvalid_reg     <= 1'b0;
      bresp_reg      <= RESP_OKAY;
    end else begin
      aw_held_reg    <= aw_held_next;
      w_held_reg     <= w_held_next;
      awaddr_reg     <= awaddr_next;
      wdata_reg      <= wdata_next;
      wlane0_reg     <= wlane0_next;
      bvalid_reg     <= bvalid_next;
      bresp_reg      <= bresp_next;
    end
  end

  // Read channel state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg     <= 1'b0;
      rresp_reg      <= RESP_OKAY;
      rdata_reg      <= 32'h00000000;
    end else begin
      rvalid_reg     <= rvalid_next;
      rresp_reg      <= rresp_next;
      rdata_reg      <= rdata_next;
    end
  end

endmodule // gpio_port

// ### gpio_port_pkg.sv
package gpio_port_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFS_DIR_OUT     = 8'h00;
  localparam logic [7:0] OFS_DIR_HW      = 8'h04;
  localparam logic [7:0] OFS_OUT_DATA    = 8'h08;
  localparam logic [7:0] OFS_IN_ENABLE   = 8'h0C;
  localparam logic [7:0] OFS_TRIG_LEVEL  = 8'h10;
  localparam logic [7:0] OFS_TRIG_BOTH   = 8'h14;
  localparam logic [7:0] OFS_TRIG_HIGH   = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK_OP = 8'h1C;
  localparam logic [7:0] OFS_IRQ_UNMASK  = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h24;
  localparam logic [7:0] OFS_IRQ_RAW     = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASKED  = 8'h2C;
  localparam logic [7:0] OFS_IRQ_ENABLED = 8'h30;
  localparam logic [7:0] OFS_PIN_SELECT  = 8'h34;
  localparam logic [7:0] OFS_PIN_LEVEL   = 8'h38;

  // Field layout: the pin-select mask occupies the low byte.
  localparam int PIN_COUNT = 8;
  localparam int SEL_LSB   = 0;

  // Reset values.
  localparam logic [7:0] RST_DIR_OUT   = 8'h00;
  localparam logic [7:0] RST_DIR_HW    = 8'h00;
  localparam logic [7:0] RST_OUT_DATA  = 8'h00;
  localparam logic [7:0] RST_IN_ENABLE = 8'h00;
  localparam logic [7:0] RST_TRIG      = 8'h00;
  localparam logic [7:0] RST_IRQ_EN    = 8'h00;
  localparam logic [7:0] RST_SELECT    = 8'hFF;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pin direction modes.
  typedef enum logic [2:0] {
    DIR_SW_INPUT         = 3'b001,
    DIR_SW_OUTPUT        = 3'b010,
    dir_hardware_control = 3'b100
  } dir_mode_t;

endpackage

// ### pin_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for the pad inputs.
module pin_sync
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // Only the second stage is read; the first may be metastable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule // pin_sync

// ### irq_detect.sv
`timescale 1ns/1ps
// Per-pin interrupt detector with five trigger kinds.
module irq_detect
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] level_in,
  input  wire logic [WIDTH-1:0] trig_level,
  input  wire logic [WIDTH-1:0] trig_both,
  input  wire logic [WIDTH-1:0] trig_high,
  input  wire logic [WIDTH-1:0] clear_sel,
  output logic      [WIDTH-1:0] raw_status
);

  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] prev_next;
  logic [WIDTH-1:0] raw_reg;
  logic [WIDTH-1:0] raw_next;
  logic [WIDTH-1:0] event_hit;

  // Edge and level events; a new event wins over a same-cycle clear.
  always_comb begin
    prev_next = level_in;
    for (int i = 0; i < WIDTH; i++) begin
      if (trig_level[i]) begin
        event_hit[i] = (level_in[i] == trig_high[i]);
      end else if (trig_both[i]) begin
        event_hit[i] = level_in[i] ^ prev_reg[i];
      end else if (trig_high[i]) begin
        event_hit[i] = level_in[i] & ~prev_reg[i];
      end else begin
        event_hit[i] = ~level_in[i] & prev_reg[i];
      end
    end
    raw_next = (raw_reg & ~clear_sel) | event_hit;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= '0;
      raw_reg  <= '0;
    end else begin
      prev_reg <= prev_next;
      raw_reg  <= raw_next;
    end
  end

  assign raw_status = raw_reg;

endmodule // irq_detect

// ### gpio_port_properties.sv
`timescale 1ns/1ps
// Port-level checks of the register bus, pin enables and interrupt line.
module gpio_port_properties
  import gpio_port_pkg::*;
#(
  parameter int NPINS = PIN_COUNT
) (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic [7:0]       s_axi_araddr,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] periph_oe,
  input wire logic             irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Reset must leave the pads undriven and the interrupt quiet one edge later.
  chk_reset_idle: assert property (disable iff (1'b0) !aresetn |=> pin_oe == '0 && !irq)
    else $error("pins or interrupt active after reset");
  // Drive enables move only on a register write or on a peripheral's own enable.
  chk_oe_cause: assert property ($changed(pin_oe) |-> $rose(s_axi_bvalid) || $changed(periph_oe))
    else $error("pin enable changed without cause");
  // The registered line and a masked-status answer load at the same edge, so they must agree.
  chk_irq_view: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_IRQ_MASKED
    |=> (s_axi_rdata[7:0] != 8'h00) == irq)
    else $error("masked status disagrees with interrupt");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_bad_addr: assert property (s_axi_arvalid && s_axi_arready
    && (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > OFS_PIN_LEVEL)
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not on second edge");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_busy_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");

  cov_irq: cover property ($rose(irq));
  cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // gpio_port_properties

bind gpio_port gpio_port_properties #(.NPINS(NPINS)) u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_oe(pin_oe),
  .periph_oe(periph_oe), .irq(irq));

// ### pin_pad_model.sv
`timescale 1ns/1ps
// Board pads and a peripheral stand-in at the far side of the port.
module pin_pad_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_level,
  input  wire logic [7:0] fn_out,
  input  wire logic [7:0] fn_oe,
  output logic      [7:0] pin_in,
  output logic      [7:0] periph_out,
  output logic      [7:0] periph_oe
);
  // A driven pad shows the port's level, an undriven one the board's.
  always_comb pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
  // Peripheral i is wired to pin i only, so no rerouting is possible here.
  always_comb begin
    periph_out = fn_out;
    periph_oe  = fn_oe;
  end
endmodule // pin_pad_model

// ### gpio_port_tb_top.sv
`timescale 1ns/1ps
module gpio_port_tb_top;
  import gpio_port_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [7:0]  awaddr, araddr, pin_in, pin_out, pin_oe, periph_out, periph_oe, periph_in;
  logic [7:0]  ext_level, fn_out, fn_oe;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          n_errors, n_tests, cyc;

  gpio_port DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_in(periph_in), .irq(irq));
  pin_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .fn_out(fn_out),
    .fn_oe(fn_oe), .pin_in(pin_in), .periph_out(periph_out), .periph_oe(periph_oe));

  // Free-running clock at 4 ns.
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Hang guard: the whole run needs a few hundred cycles at most.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Ready is judged mid-cycle, where it is settled, and acts at the next rising edge.
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ad = 1'b0;
    logic wd = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ad = ad | (awvalid & awready);
      wd = wd | (wvalid & wready);
      @(posedge aclk);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end while (!(ad && wd));
    do @(negedge aclk); while (bvalid !== 1'b1);
    chk(bresp, er);
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic t_reset();
    repeat (4) @(posedge aclk);
    rd_chk(OFS_PIN_LEVEL, 32'h0);
    rd_chk(OFS_PIN_SELECT, 32'hFF);
    rd_chk(OFS_IRQ_ENABLED, 32'h0);
  endtask

  task automatic t_pins();
    axi_wr(OFS_IN_ENABLE, 8'hFF, RESP_OKAY);
    axi_wr(OFS_DIR_OUT, 8'h0F, RESP_OKAY);
    axi_wr(OFS_OUT_DATA, 8'h06, RESP_OKAY);
    axi_wr(OFS_PIN_SELECT, 8'h3C, RESP_OKAY);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk(pin_oe, 8'h0F);
    chk(pin_out & pin_oe, 8'h06);
    @(posedge aclk);
    rd_chk(OFS_PIN_LEVEL, 32'h24);
    axi_wr(OFS_PIN_SELECT, 8'h81, RESP_OKAY);
    rd_chk(OFS_PIN_LEVEL, 32'h80);
    axi_wr(OFS_PIN_SELECT, 8'hFF, RESP_OKAY);
  endtask

  // Pins 4 and 7 go to their peripherals; the others keep their software roles.
  task automatic t_hw();
    axi_wr(OFS_DIR_HW, 8'h90, RESP_OKAY);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk(pin_oe, 8'h9F);
    chk(pin_out & pin_oe, 8'h16);
    chk(periph_in, 8'h10);
    @(posedge aclk);
    rd_chk(OFS_PIN_LEVEL, 32'h36);
    axi_wr(OFS_DIR_HW, 8'h00, RESP_OKAY);
    repeat (4) @(posedge aclk);
  endtask

  task automatic irq_is(input logic exp);
    @(negedge aclk);
    chk(irq, exp);
    @(posedge aclk);
  endtask

  // Entries are level, both, high, start level, end level for pin 4.
  task automatic t_irq();
    logic [4:0] k [5] = '{5'b00010, 5'b00101, 5'b01010, 5'b10010, 5'b10101};
    foreach (k[i]) begin
      ext_level[4] <= k[i][1];
      repeat (4) @(posedge aclk);
      axi_wr(OFS_TRIG_LEVEL, {3'h0, k[i][4], 4'h0}, RESP_OKAY);
      axi_wr(OFS_TRIG_BOTH, {3'h0, k[i][3], 4'h0}, RESP_OKAY);
      axi_wr(OFS_TRIG_HIGH, {3'h0, k[i][2], 4'h0}, RESP_OKAY);
      axi_wr(OFS_IRQ_CLEAR, 8'hFF, RESP_OKAY);
      rd_chk(OFS_IRQ_RAW, 32'h0);
      ext_level[4] <= k[i][0];
      repeat (4) @(posedge aclk);
      rd_chk(OFS_IRQ_RAW, 32'h10);
      rd_chk(OFS_IRQ_MASKED, 32'h0);
      axi_wr(OFS_IRQ_CLEAR, 8'hEF, RESP_OKAY);
      rd_chk(OFS_IRQ_RAW, 32'h10);
      axi_wr(OFS_IRQ_CLEAR, 8'h10, RESP_OKAY);
      rd_chk(OFS_IRQ_RAW, {27'h0, k[i][4], 4'h0});
    end
    axi_wr(OFS_IRQ_UNMASK, 8'h40, RESP_OKAY);
    irq_is(1'b0);
    axi_wr(OFS_IRQ_UNMASK, 8'h10, RESP_OKAY);
    rd_chk(OFS_IRQ_ENABLED, 32'h50);
    rd_chk(OFS_IRQ_MASKED, 32'h10);
    irq_is(1'b1);
    axi_wr(OFS_IRQ_MASK_OP, 8'h40, RESP_OKAY);
    rd_chk(OFS_IRQ_ENABLED, 32'h10);
    axi_wr(OFS_IRQ_MASK_OP, 8'h10, RESP_OKAY);
    irq_is(1'b0);
    rd_chk(OFS_IRQ_RAW, 32'h10);
    ext_level[4] <= 1'b0;
    repeat (4) @(posedge aclk);
    axi_wr(OFS_IRQ_UNMASK, 8'h10, RESP_OKAY);
    irq_is(1'b1);
    axi_wr(OFS_IRQ_CLEAR, 8'h10, RESP_OKAY);
    irq_is(1'b0);
  endtask

  // Unmapped and unaligned places are refused with zero data.
  task automatic t_bus();
    logic [7:0]  a [3] = '{8'h3C, 8'h02, 8'h80};
    logic [31:0] d;
    logic [1:0]  r;
    foreach (a[i]) begin
      axi_rd(a[i], d, r);
      chk(d, 32'h0);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
    end
    axi_wr(8'h40, 8'hFF, RESP_SLVERR);
  endtask

  // The master holds off bready and rready; each answer must stand until it is taken.
  task automatic t_stall();
    logic [31:0] d;
    logic [1:0]  r;
    {bready, rready} <= 2'h0;
    axi_wr(OFS_PIN_SELECT, 8'h5A, RESP_OKAY);
    repeat (3) @(negedge aclk);
    chk({31'h0, bvalid}, 32'h1);
    chk({31'h0, awready}, 32'h0);
    chk({30'h0, bresp}, {30'h0, RESP_OKAY});
    @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    axi_rd(OFS_PIN_SELECT, d, r);
    chk(d, 32'h5A);
    repeat (3) @(negedge aclk);
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, 32'h5A);
    @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    @(negedge aclk);
    chk({31'h0, rvalid}, 32'h0);
    @(posedge aclk);
    axi_wr(OFS_PIN_SELECT, 8'hFF, RESP_OKAY);
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    ext_level = 8'hA5;
    fn_out = 8'h55;
    fn_oe = 8'hF0;
    n_errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_pins();
    t_hw();
    t_irq();
    t_stall();
    t_bus();
    complete_run();
  end
endmodule // gpio_port_tb_top
